// ===== src/modulation_processor_matrix.sv
// per-voice modulation matrix: cords, clock divisors and modulation processors
// Summary of operation
// - routed clock restarts filter or aux envelope on its rising edge
// - routed clock resets an LFO phase on its falling edge
// - sequencer clock offered as six divided square-wave sources
// - a clock passes a cord only when its amount is positive
// - switch outputs one when its input sum exceeds zero, else zero
// - a logic one from a non-clock source arrives at a destination as the cord amount
// - summing amp adds its cords into one shareable source
// - lag outputs slew toward their input at a programmed rate
// - each lag input sum is also a source of its own
// - absolute value output is never negative
// - diode passes positive values, outputs zero for negative ones
// - flip-flop toggles each time its input goes from non-positive to positive
// - quantizer gives 16 steps at full input; cords set count and size
// - gain processor multiplies its input by four
// - many sources may feed one destination and one source many
// - note-on sources held for the note, realtime sources update always
// - centred velocity maps 64 to zero
// - a negative cord amount inverts the contribution of any non-clock source
// - latching footswitch toggles on each press
// - a processor input sums several sources, including a DC offset
// - each of the 24 cord amounts is itself a destination
// - contributions add to the initial value of pitch, filter and volume
module modulation_processor_matrix
  import mod_matrix_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic note_start,
  input wire logic [6:0] key_num,
  input wire logic [6:0] velocity,
  input wire logic gate,
  input wire mod_matrix_pkg::mod_val_t wheel,
  input wire mod_matrix_pkg::mod_val_t pedal,
  input wire logic foot_pin,
  input wire logic seq_tick_pin,
  output mod_matrix_pkg::mod_val_t pitch_mod,
  output mod_matrix_pkg::mod_val_t filter_mod,
  output mod_matrix_pkg::mod_val_t volume_mod,
  output logic filt_env_restart,
  output logic aux_env_restart,
  output logic lfo1_phase_reset,
  output logic lfo2_phase_reset
);
  import mod_matrix_pkg::*;

  logic ack_q;
  logic [31:0] rd_d;
  logic [31:0] ctrl_q;
  mod_val_t cord_amt_q [CORD_COUNT];
  src_sel_t cord_src_q [CORD_COUNT];
  dest_sel_t cord_dst_q [CORD_COUNT];
  mod_val_t init_q [3];
  mod_val_t amt_mod_q [CORD_COUNT];
  mod_val_t acc_q [64];
  mod_val_t src_val [32];
  frame_state_t state_q;
  logic [4:0] cord_idx_q;
  logic [15:0] frame_cnt_q;
  logic [2:0] foot_sync_q;
  logic [2:0] tick_sync_q;
  logic foot_rise;
  logic tick_rise;
  logic foot_latch_q;
  logic [5:0] tick_cnt_q;
  logic [6:0] key_q;
  logic [6:0] vel_q;
  logic gate_q;
  logic [15:0] lfsr_q;
  mod_val_t random_q;
  mod_val_t sum_q, lag0_in_q, lag1_in_q, lag0_q, lag1_q;
  mod_val_t switch_q, abs_q, diode_q, ff_q, quant_q, gain_q;
  logic ff_pos_q;
  logic [TRIG_COUNT-1:0] trig_lvl_q;
  logic [TRIG_COUNT-1:0] trig_pulse_q;
  logic run;
  mod_val_t amt_eff;
  src_sel_t cur_src;
  dest_sel_t cur_dst;
  cord_mul_if mul ();

  assign run = ctrl_q[CTRL_RUN_BIT];

  // one wait state per access: the read word is captured while waitrequest is high
  assign waitrequest = (read || write) && !ack_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (read || write) && !ack_q;
    end
  end

  // read decode, unmapped words read as zero
  always_comb begin
    rd_d = 32'h0000_0000;
    if (address == REG_CTRL) begin
      rd_d = ctrl_q;
    end else if (address == REG_STATUS) begin
      rd_d = {frame_cnt_q, 13'h0000, foot_latch_q, ff_pos_q, trig_lvl_q[0]};
    end else if (address >= REG_CORD_BASE && address < REG_CORD_BASE + 8'h18) begin
      rd_d = {2'h0, cord_dst_q[address[4:0] - 5'h00],
              3'h0, cord_src_q[address[4:0]], cord_amt_q[address[4:0]]};
    end else if (address >= REG_INIT_BASE && address < REG_INIT_BASE + 8'h03) begin
      rd_d = {{16{init_q[address[1:0]][15]}}, init_q[address[1:0]]};
    end else if (address >= REG_SRC_BASE && address < REG_SRC_BASE + 8'h20) begin
      rd_d = {{16{src_val[address[4:0]][15]}}, src_val[address[4:0]]};
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= 32'h0000_0000;
    end else if (read && !ack_q) begin
      readdata <= rd_d;
    end
  end

  // register writes land on the edge that ends the wait
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= CTRL_RESET;
      for (int i = 0; i < CORD_COUNT; i++) begin
        cord_amt_q[i] <= VAL_ZERO;
        cord_src_q[i] <= SRC_NONE;
        cord_dst_q[i] <= DST_NONE;
      end
      for (int i = 0; i < 3; i++) begin
        init_q[i] <= VAL_ZERO;
      end
    end else if (write && ack_q) begin
      if (address == REG_CTRL) begin
        ctrl_q <= writedata;
      end else if (address >= REG_CORD_BASE && address < REG_CORD_BASE + 8'h18) begin
        cord_amt_q[address[4:0]] <= writedata[15:0];
        cord_src_q[address[4:0]] <= src_sel_t'(writedata[CORD_SRC_LSB +: 5]);
        cord_dst_q[address[4:0]] <= dest_sel_t'(writedata[CORD_DST_LSB +: 6]);
      end else if (address >= REG_INIT_BASE && address < REG_INIT_BASE + 8'h03) begin
        init_q[address[1:0]] <= writedata[15:0];
      end
    end
  end

  // pin synchronisers; the first stage feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      foot_sync_q <= 3'h0;
      tick_sync_q <= 3'h0;
    end else begin
      foot_sync_q <= {foot_sync_q[1:0], foot_pin};
      tick_sync_q <= {tick_sync_q[1:0], seq_tick_pin};
    end
  end
  assign foot_rise = foot_sync_q[1] && !foot_sync_q[2];
  assign tick_rise = tick_sync_q[1] && !tick_sync_q[2];

  // latching footswitch
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      foot_latch_q <= 1'b0;
    end else if (foot_rise) begin
      foot_latch_q <= !foot_latch_q;
    end
  end

  // tick counter: bit n is a square wave of 2^(n+1) ticks, so one counter gives all divisors
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_q <= 6'h00;
    end else if (tick_rise) begin
      tick_cnt_q <= tick_cnt_q + 6'h01;
    end
  end

  // note-on values are caught once per note; the lfsr runs free for the random source
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      key_q <= 7'h00;
      vel_q <= VEL_CENTRE;
      gate_q <= 1'b0;
      random_q <= VAL_ZERO;
      lfsr_q <= 16'hACE1;
    end else begin
      lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      if (note_start) begin
        key_q <= key_num;
        vel_q <= velocity;
        gate_q <= gate;
        random_q <= lfsr_q;
      end
    end
  end

  // source table; realtime inputs pass straight through
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      src_val[i] = VAL_ZERO;
    end
    src_val[SRC_DC] = LOGIC_ONE;
    src_val[SRC_KEY] = {1'b0, key_q, 8'h00};
    src_val[SRC_VEL_CENTRED] = 16'(signed'({1'b0, vel_q}) - signed'({1'b0, VEL_CENTRE})) <<< 9;
    src_val[SRC_GATE] = gate_q ? LOGIC_ONE : VAL_ZERO;
    src_val[SRC_WHEEL] = wheel;
    src_val[SRC_PEDAL] = pedal;
    src_val[SRC_FOOT_LATCH] = foot_latch_q ? LOGIC_ONE : VAL_ZERO;
    for (int i = 0; i < 6; i++) begin
      src_val[SRC_CLK_SIXTEENTH - i] = tick_cnt_q[i] ? LOGIC_ONE : VAL_ZERO;
    end
    src_val[SRC_LAG0_IN] = lag0_in_q;
    src_val[SRC_LAG1_IN] = lag1_in_q;
    src_val[SRC_LAG0] = lag0_q;
    src_val[SRC_LAG1] = lag1_q;
    src_val[SRC_SUM] = sum_q;
    src_val[SRC_SWITCH] = switch_q;
    src_val[SRC_ABS] = abs_q;
    src_val[SRC_DIODE] = diode_q;
    src_val[SRC_FLIPFLOP] = ff_q;
    src_val[SRC_QUANT] = quant_q;
    src_val[SRC_GAIN4] = gain_q;
    src_val[SRC_RANDOM] = random_q;
  end

  // current cord; its amount is itself modulated by last frame's cord-amount sums
  assign cur_src = cord_src_q[cord_idx_q];
  assign cur_dst = cord_dst_q[cord_idx_q];
  assign amt_eff = sat_add(cord_amt_q[cord_idx_q], amt_mod_q[cord_idx_q]);
  assign mul.src = src_val[cur_src];
  assign mul.amt = amt_eff;
  assign mul.is_clock = cur_src >= SRC_CLK_DWHOLE && cur_src <= SRC_CLK_SIXTEENTH;

  cord_scale u_scale (
    .mul(mul.scaler)
  );

  // frame sequencer: 24 scan cycles, then one evaluation cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ST_SCAN;
      cord_idx_q <= 5'h00;
      frame_cnt_q <= 16'h0000;
    end else begin
      case (state_q)
        ST_SCAN: begin
          if (run && cord_idx_q == CORD_LAST) begin
            state_q <= ST_EVAL;
          end else if (run) begin
            cord_idx_q <= cord_idx_q + 5'h01;
          end
        end
        ST_EVAL: begin
          state_q <= ST_SCAN;
          cord_idx_q <= 5'h00;
          frame_cnt_q <= frame_cnt_q + 16'h0001;
        end
        default: begin
          state_q <= ST_SCAN;
        end
      endcase
    end
  end

  // destination accumulators, one cord added per scan cycle, cleared at evaluation
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < 64; i++) begin
        acc_q[i] <= VAL_ZERO;
      end
    end else if (state_q == ST_EVAL) begin
      for (int i = 0; i < 64; i++) begin
        acc_q[i] <= VAL_ZERO;
      end
    end else if (run) begin
      acc_q[cur_dst] <= sat_add(acc_q[cur_dst], mul.prod);
    end
  end

  // cord-amount modulation taken over for the next frame
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < CORD_COUNT; i++) begin
        amt_mod_q[i] <= VAL_ZERO;
      end
    end else if (state_q == ST_EVAL) begin
      for (int i = 0; i < CORD_COUNT; i++) begin
        amt_mod_q[i] <= acc_q[DST_CORD_AMT + i];
      end
    end
  end

  // realtime destinations: initial value plus the cord sum
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pitch_mod <= VAL_ZERO;
      filter_mod <= VAL_ZERO;
      volume_mod <= VAL_ZERO;
    end else if (state_q == ST_EVAL) begin
      pitch_mod <= sat_add(init_q[0], acc_q[DST_PITCH]);
      filter_mod <= sat_add(init_q[1], acc_q[DST_FILTER]);
      volume_mod <= sat_add(init_q[2], acc_q[DST_VOLUME]);
    end
  end

  // processors, all fed from this frame's sums so the order never changes a result
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sum_q <= VAL_ZERO;
      lag0_in_q <= VAL_ZERO;
      lag1_in_q <= VAL_ZERO;
      lag0_q <= VAL_ZERO;
      lag1_q <= VAL_ZERO;
      switch_q <= VAL_ZERO;
      abs_q <= VAL_ZERO;
      diode_q <= VAL_ZERO;
      quant_q <= VAL_ZERO;
      gain_q <= VAL_ZERO;
    end else if (state_q == ST_EVAL) begin
      sum_q <= acc_q[DST_SUM];
      lag0_in_q <= acc_q[DST_LAG0_IN];
      lag1_in_q <= acc_q[DST_LAG1_IN];
      // slew by a shifted share of the gap: never overshoots, rate 0 follows at once
      lag0_q <= 16'((signed'({acc_q[DST_LAG0_IN][15], acc_q[DST_LAG0_IN]})
                 - signed'({lag0_q[15], lag0_q})) >>> ctrl_q[CTRL_LAG0_LSB +: 4])
                + lag0_q;
      lag1_q <= 16'((signed'({acc_q[DST_LAG1_IN][15], acc_q[DST_LAG1_IN]})
                 - signed'({lag1_q[15], lag1_q})) >>> ctrl_q[CTRL_LAG1_LSB +: 4])
                + lag1_q;
      switch_q <= (acc_q[DST_SWITCH] > VAL_ZERO) ? LOGIC_ONE : VAL_ZERO;
      abs_q <= (acc_q[DST_ABS] < VAL_ZERO) ? sat_add(VAL_ZERO - 16'sh0001 - acc_q[DST_ABS],
               16'sh0001) : acc_q[DST_ABS];
      diode_q <= (acc_q[DST_DIODE] > VAL_ZERO) ? acc_q[DST_DIODE] : VAL_ZERO;
      quant_q <= acc_q[DST_QUANT] & QUANT_MASK;
      gain_q <= sat18({{2{acc_q[DST_GAIN4][15]}}, acc_q[DST_GAIN4]} <<< 2);
    end
  end

  // flip-flop processor toggles on an upward zero crossing
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ff_q <= VAL_ZERO;
      ff_pos_q <= 1'b0;
    end else if (state_q == ST_EVAL) begin
      ff_pos_q <= acc_q[DST_FLIPFLOP] > VAL_ZERO;
      if (acc_q[DST_FLIPFLOP] > VAL_ZERO && !ff_pos_q) begin
        ff_q <= (ff_q == VAL_ZERO) ? LOGIC_ONE : VAL_ZERO;
      end
    end
  end

  // trigger destinations: envelopes fire on a rise, lfos on a fall
  for (genvar t = 0; t < TRIG_COUNT; t++) begin : g_trig
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        trig_lvl_q[t] <= 1'b0;
        trig_pulse_q[t] <= 1'b0;
      end else if (state_q == ST_EVAL) begin
        trig_lvl_q[t] <= acc_q[DST_FILT_ENV_TRIG + t] > VAL_ZERO;
        if (t < 2) begin
          trig_pulse_q[t] <= acc_q[DST_FILT_ENV_TRIG + t] > VAL_ZERO && !trig_lvl_q[t];
        end else begin
          trig_pulse_q[t] <= acc_q[DST_FILT_ENV_TRIG + t] <= VAL_ZERO && trig_lvl_q[t];
        end
      end else begin
        trig_pulse_q[t] <= 1'b0;
      end
    end
  end
  assign filt_env_restart = trig_pulse_q[0];
  assign aux_env_restart = trig_pulse_q[1];
  assign lfo1_phase_reset = trig_pulse_q[2];
  assign lfo2_phase_reset = trig_pulse_q[3];

  sequence eval_s;
    state_q == ST_EVAL;
  endsequence
  sequence clock_cord_s;
    state_q == ST_SCAN && mul.is_clock;
  endsequence

  chk_env_rise_edge: assert property (@(posedge clk) disable iff (!rst_b)
    eval_s ##0 (acc_q[DST_FILT_ENV_TRIG] > VAL_ZERO && !trig_lvl_q[0]) |=> filt_env_restart)
    else $error("envelope restart missed on rising edge");
  chk_lfo_fall_edge: assert property (@(posedge clk) disable iff (!rst_b)
    lfo1_phase_reset |-> !trig_lvl_q[2] && $past(trig_lvl_q[2]))
    else $error("lfo reset not on falling edge");
  chk_divider_count: assert property (@(posedge clk) disable iff (!rst_b)
    tick_rise |=> tick_cnt_q == $past(tick_cnt_q) + 6'h01)
    else $error("clock divider did not advance");
  chk_clock_blocked: assert property (@(posedge clk) disable iff (!rst_b)
    clock_cord_s ##0 (mul.amt <= VAL_ZERO) |-> mul.prod == VAL_ZERO)
    else $error("clock passed a non-positive cord");
  chk_switch_out: assert property (@(posedge clk) disable iff (!rst_b)
    eval_s |=> switch_q == (($past(acc_q[DST_SWITCH]) > VAL_ZERO) ? LOGIC_ONE : VAL_ZERO))
    else $error("switch output wrong");
  chk_one_is_amount: assert property (@(posedge clk) disable iff (!rst_b)
    (mul.src == LOGIC_ONE && !mul.is_clock) |-> mul.prod == mul.amt)
    else $error("logic one not scaled to cord amount");
  chk_abs_positive: assert property (@(posedge clk) disable iff (!rst_b)
    abs_q >= VAL_ZERO && diode_q >= VAL_ZERO)
    else $error("abs or diode output negative");
  chk_ff_toggle: assert property (@(posedge clk) disable iff (!rst_b)
    eval_s ##0 (acc_q[DST_FLIPFLOP] > VAL_ZERO && !ff_pos_q) |=> ff_q != $past(ff_q))
    else $error("flip-flop did not toggle");
  chk_gain_four: assert property (@(posedge clk) disable iff (!rst_b)
    eval_s ##0 (acc_q[DST_GAIN4] < 16'sh2000 && acc_q[DST_GAIN4] > -16'sh2000)
    |=> gain_q == 16'($past(acc_q[DST_GAIN4]) * 4))
    else $error("gain not four times input");
  chk_note_hold: assert property (@(posedge clk) disable iff (!rst_b)
    !note_start |=> $stable(vel_q) && $stable(key_q))
    else $error("note-on value changed mid note");
  chk_foot_latch: assert property (@(posedge clk) disable iff (!rst_b)
    foot_rise |=> foot_latch_q != $past(foot_latch_q))
    else $error("footswitch latch did not toggle");
  chk_frame_order: assert property (@(posedge clk) disable iff (!rst_b)
    eval_s |-> $past(cord_idx_q) == CORD_LAST ##1 state_q == ST_SCAN && cord_idx_q == 5'h00)
    else $error("evaluation out of frame order");
endmodule : modulation_processor_matrix

// ===== src/mod_matrix_pkg.sv
// shared constants, types and saturating arithmetic for the modulation matrix
package mod_matrix_pkg;
  typedef logic signed [15:0] mod_val_t;
  localparam mod_val_t VAL_MAX = 16'sh7FFF;
  localparam mod_val_t VAL_MIN = 16'sh8000;
  localparam mod_val_t VAL_ZERO = 16'sh0000;
  localparam mod_val_t LOGIC_ONE = 16'sh7FFF; // a digital one is full scale
  localparam mod_val_t QUANT_MASK = 16'shF800; // 16 levels over the positive range
  localparam logic [6:0] VEL_CENTRE = 7'h40;
  localparam int CORD_COUNT = 24;
  localparam logic [4:0] CORD_LAST = 5'h17;
  localparam int TRIG_COUNT = 4;
  // register word addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h01;
  localparam logic [7:0] REG_CORD_BASE = 8'h20;
  localparam logic [7:0] REG_INIT_BASE = 8'h40;
  localparam logic [7:0] REG_SRC_BASE = 8'h60;
  // field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_LAG0_LSB = 4;
  localparam int CTRL_LAG1_LSB = 8;
  localparam int CORD_SRC_LSB = 16;
  localparam int CORD_DST_LSB = 24;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0441;
  typedef enum logic [4:0] {
    SRC_NONE = 5'h00, SRC_DC = 5'h01, SRC_KEY = 5'h02, SRC_VEL_CENTRED = 5'h03,
    SRC_GATE = 5'h04, SRC_WHEEL = 5'h05, SRC_PEDAL = 5'h06, SRC_FOOT_LATCH = 5'h07,
    SRC_CLK_DWHOLE = 5'h08, SRC_CLK_WHOLE = 5'h09, SRC_CLK_HALF = 5'h0A,
    SRC_CLK_QUARTER = 5'h0B, SRC_CLK_EIGHTH = 5'h0C, SRC_CLK_SIXTEENTH = 5'h0D,
    SRC_LAG0_IN = 5'h0E, SRC_LAG1_IN = 5'h0F, SRC_LAG0 = 5'h10, SRC_LAG1 = 5'h11,
    SRC_SUM = 5'h12, SRC_SWITCH = 5'h13, SRC_ABS = 5'h14, SRC_DIODE = 5'h15,
    SRC_FLIPFLOP = 5'h16, SRC_QUANT = 5'h17, SRC_GAIN4 = 5'h18, SRC_RANDOM = 5'h19
  } src_sel_t;
  typedef enum logic [5:0] {
    DST_NONE = 6'h00, DST_PITCH = 6'h01, DST_FILTER = 6'h02, DST_VOLUME = 6'h03,
    DST_FILT_ENV_TRIG = 6'h04, DST_AUX_ENV_TRIG = 6'h05, DST_LFO1_TRIG = 6'h06,
    DST_LFO2_TRIG = 6'h07, DST_LAG0_IN = 6'h08, DST_LAG1_IN = 6'h09, DST_SUM = 6'h0A,
    DST_SWITCH = 6'h0B, DST_ABS = 6'h0C, DST_DIODE = 6'h0D, DST_FLIPFLOP = 6'h0E,
    DST_QUANT = 6'h0F, DST_GAIN4 = 6'h10, DST_CORD_AMT = 6'h20
  } dest_sel_t;
  typedef enum logic [0:0] {ST_SCAN = 1'b0, ST_EVAL = 1'b1} frame_state_t;

  // clip an 18-bit intermediate to the value range instead of wrapping
  function automatic mod_val_t sat18(input logic signed [17:0] v);
    if (v > 18'sh07FFF) begin
      return VAL_MAX;
    end else if (v < -18'sh08000) begin
      return VAL_MIN;
    end
    return v[15:0];
  endfunction : sat18

  function automatic mod_val_t sat_add(input mod_val_t a, input mod_val_t b);
    return sat18({{2{a[15]}}, a} + {{2{b[15]}}, b});
  endfunction : sat_add
endpackage : mod_matrix_pkg

// ===== src/cord_mul_if.sv
// carrier between the frame scanner and the cord scaler
interface cord_mul_if;
  import mod_matrix_pkg::*;
  mod_val_t src;
  mod_val_t amt;
  logic is_clock;
  mod_val_t prod;
  modport scaler (input src, input amt, input is_clock, output prod);
  modport requester (output src, output amt, output is_clock, input prod);
endinterface : cord_mul_if

// ===== src/cord_scale.sv
// scales one source by its signed cord amount
module cord_scale
  import mod_matrix_pkg::*;
(
  cord_mul_if.scaler mul
);
  logic signed [31:0] full;
  logic signed [31:0] shifted;

  // full-scale product, dropped back to the value format
  assign full = mul.src * mul.amt;
  assign shifted = full >>> 15;

  // clocks pass only through a positive cord; a one lands exactly as the amount
  always_comb begin
    if (mul.is_clock) begin
      mul.prod = (mul.amt > VAL_ZERO && mul.src == LOGIC_ONE) ? mul.amt : VAL_ZERO;
    end else if (mul.src == LOGIC_ONE) begin
      mul.prod = mul.amt;
    end else if (shifted > 32'sh0000_7FFF) begin
      mul.prod = VAL_MAX;
    end else begin
      mul.prod = shifted[15:0];
    end
  end
endmodule : cord_scale

// ===== testbench/modulation_processor_matrix_tb_top.sv
// self-checking bench for the modulation matrix: bus, cords and processor sources
module modulation_processor_matrix_tb_top
  import mod_matrix_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic read = 1'b0;
  logic write = 1'b0;
  logic note_start = 1'b0;
  logic gate = 1'b0;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0000_0000;
  logic [6:0] key_num = 7'h00;
  logic [6:0] velocity = 7'h40;
  mod_val_t wheel = 16'sh0000;
  mod_val_t pedal = 16'sh0000;
  logic [31:0] readdata;
  logic waitrequest;
  mod_val_t pitch_mod;
  mod_val_t filter_mod;
  mod_val_t volume_mod;
  logic foot = 1'b0;
  logic tick = 1'b0;
  wire [3:0] trig;
  int pulses [4] = '{0, 0, 0, 0};
  mod_val_t fm_q[$];
  mod_val_t vm_q[$];
  logic [31:0] rd_q[$];
  mod_val_t pm_q[$];
  int mismatches = 0;
  int n_checks = 0;

  modulation_processor_matrix dut (
    .clk(clk), .rst_b(rst_b), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .note_start(note_start), .key_num(key_num), .velocity(velocity), .gate(gate),
    .wheel(wheel), .pedal(pedal), .foot_pin(foot), .seq_tick_pin(tick),
    .pitch_mod(pitch_mod), .filter_mod(filter_mod), .volume_mod(volume_mod),
    .filt_env_restart(trig[0]), .aux_env_restart(trig[1]), .lfo1_phase_reset(trig[2]),
    .lfo2_phase_reset(trig[3])
  );

  // 50 MHz clock
  initial forever #10 clk = ~clk;

  task automatic check_word(input string what, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask : check_word

  task automatic check_mod(input string what, input mod_val_t e, input mod_val_t s);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask : check_mod

  // watcher: read data is taken only at the edge where waitrequest is low
  always @(posedge clk) begin
    if (read === 1'b1 && waitrequest === 1'b0 && rd_q.size() > 0) begin
      check_word("readdata", rd_q.pop_front(), readdata);
    end
    if (pm_q.size() > 0) begin
      check_mod("pitch_mod", pm_q.pop_front(), pitch_mod);
    end
    if (fm_q.size() > 0) begin
      check_mod("filter_mod", fm_q.pop_front(), filter_mod);
    end
    if (vm_q.size() > 0) begin
      check_mod("volume_mod", vm_q.pop_front(), volume_mod);
    end
    // trigger pulses stand one cycle, so each is counted exactly once
    for (int t = 0; t < 4; t++) begin
      if (trig[t] === 1'b1) begin
        pulses[t]++;
      end
    end
  end

  // one avalon access; the request stands until a rising edge samples waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge clk);
    end while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    bus(1'b0, a, 32'h0000_0000);
  endtask : rd

  function automatic logic [31:0] sx(input mod_val_t v);
    return {{16{v[15]}}, v};
  endfunction : sx

  function automatic logic [31:0] cw(input logic [4:0] s, input logic [5:0] d, input mod_val_t a);
    return {2'b00, d, 3'b000, s, a};
  endfunction : cw

  // a frame is 25 clocks; chains need an extra frame per stage, so wait generously
  task automatic frames(input int k);
    repeat (k * 25) @(posedge clk);
  endtask : frames

  // one press of the footswitch or one sequencer tick, w cycles high then w low
  task automatic pulse(input logic ft, input int w);
    @(posedge clk);
    if (ft) begin
      foot <= 1'b1;
    end else begin
      tick <= 1'b1;
    end
    repeat (w) @(posedge clk);
    foot <= 1'b0;
    tick <= 1'b0;
    repeat (w) @(posedge clk);
  endtask : pulse

  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  // watchdog: the whole sequence needs well under two thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    $display("wrong value run time expected finish seen timeout");
    summarize;
  end

  // main sequence
  initial begin
    mod_val_t a, b, c, i0, vc;
    logic [6:0] v;
    int k;
    void'($urandom(47732));
    a = 16'($urandom_range(16'h3000, 1));
    b = 16'($urandom_range(16'h3000, 1));
    c = 16'($urandom_range(16'h3FFF, 1));
    i0 = 16'($urandom_range(16'h1000, 0));
    v = 7'($urandom_range(127, 65));
    vc = 16'((int'(v) - 64) * 512);
    k = $urandom_range(7, 3);
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    wheel <= 16'($urandom);
    rd(REG_CTRL, CTRL_RESET);
    wr(8'h10, 32'hFFFF_FFFF);
    rd(8'h10, 32'h0000_0000);
    wr(REG_INIT_BASE, sx(i0));
    rd(REG_INIT_BASE, sx(i0));
    @(posedge clk);
    velocity <= v;
    note_start <= 1'b1;
    @(posedge clk);
    note_start <= 1'b0;
    velocity <= 7'h00; // a held note must not follow this change
    wr(REG_CORD_BASE, cw(SRC_DC, DST_PITCH, a));
    wr(REG_CORD_BASE + 8'h01, cw(SRC_DC, DST_PITCH, b));
    wr(REG_CORD_BASE + 8'h02, cw(SRC_DC, DST_ABS, -c));
    wr(REG_CORD_BASE + 8'h03, cw(SRC_DC, DST_DIODE, -c));
    wr(REG_CORD_BASE + 8'h04, cw(SRC_DC, DST_GAIN4, 16'sh0100));
    wr(REG_CORD_BASE + 8'h05, cw(SRC_DC, DST_QUANT, 16'sh1234));
    wr(REG_CORD_BASE + 8'h06, cw(SRC_VEL_CENTRED, DST_SWITCH, 16'sh7FFF));
    wr(REG_CORD_BASE + 8'h07, cw(SRC_DC, DST_LAG1_IN, 16'sh0100));
    wr(REG_CORD_BASE + 8'h17, cw(SRC_DC, DST_LAG1_IN, 16'sh0200));
    wr(REG_INIT_BASE + 8'h01, sx(i0));
    wr(REG_CORD_BASE + 8'h08, cw(SRC_CLK_SIXTEENTH, DST_FILT_ENV_TRIG, 16'sh4000));
    wr(REG_CORD_BASE + 8'h09, cw(SRC_CLK_SIXTEENTH, DST_AUX_ENV_TRIG, -16'sh4000));
    wr(REG_CORD_BASE + 8'h0A, cw(SRC_CLK_SIXTEENTH, DST_LFO1_TRIG, 16'sh4000));
    wr(REG_CORD_BASE + 8'h0B, cw(SRC_CLK_SIXTEENTH, DST_LFO2_TRIG, 16'sh0000));
    wr(REG_CORD_BASE + 8'h0C, cw(SRC_DC, DST_SUM, 16'sh7FFF));
    wr(REG_CORD_BASE + 8'h0D, cw(SRC_SUM, DST_VOLUME, b));
    wr(REG_CORD_BASE + 8'h0E, cw(SRC_DC, DST_FILTER, -a));
    wr(REG_CORD_BASE + 8'h0F, cw(SRC_DC, 6'h2D, c));
    wr(REG_CORD_BASE + 8'h10, cw(SRC_CLK_SIXTEENTH, DST_FLIPFLOP, 16'sh4000));
    frames(4);
    pm_q.push_back(i0 + a + b);
    fm_q.push_back(i0 - a);
    vm_q.push_back(b + c);
    rd(REG_SRC_BASE + 8'h14, sx(c));
    rd(REG_SRC_BASE + 8'h15, 32'h0000_0000);
    rd(REG_SRC_BASE + 8'h18, 32'h0000_0400);
    rd(REG_SRC_BASE + 8'h17, 32'h0000_1000);
    rd(REG_SRC_BASE + 8'h13, sx(LOGIC_ONE));
    rd(REG_SRC_BASE + 8'h03, sx(vc));
    rd(REG_SRC_BASE + 8'h0F, 32'h0000_0300);
    rd(REG_SRC_BASE + 8'h05, sx(wheel));
    wr(REG_CORD_BASE + 8'h03, cw(SRC_DC, DST_DIODE, c));
    wr(REG_CORD_BASE + 8'h04, cw(SRC_DC, DST_GAIN4, 16'sh4000));
    wr(REG_CORD_BASE + 8'h06, cw(SRC_VEL_CENTRED, DST_SWITCH, 16'sh8001));
    frames(4);
    rd(REG_SRC_BASE + 8'h15, sx(c));
    rd(REG_SRC_BASE + 8'h18, sx(VAL_MAX));
    rd(REG_SRC_BASE + 8'h13, 32'h0000_0000);
    pulse(1'b1, 4);
    rd(REG_SRC_BASE + 8'h07, sx(LOGIC_ONE));
    pulse(1'b1, 4);
    rd(REG_SRC_BASE + 8'h07, 32'h0000_0000);
    // each tick level lasts longer than one frame (30 clocks against 25) so every edge is seen at evaluation
    repeat (k) pulse(1'b0, 30);
    frames(3);
    rd(REG_SRC_BASE + 8'h0D, k[0] ? sx(LOGIC_ONE) : 32'h0000_0000);
    rd(REG_SRC_BASE + 8'h0B, k[2] ? sx(LOGIC_ONE) : 32'h0000_0000);
    rd(REG_SRC_BASE + 8'h16, ((k + 1) / 2) % 2 ? sx(LOGIC_ONE) : 32'h0000_0000);
    check_word("filt_env_restart pulses", (k + 1) / 2, pulses[0]);
    check_word("aux_env_restart pulses", 32'h0000_0000, pulses[1]);
    check_word("lfo1_phase_reset pulses", k / 2, pulses[2]);
    check_word("lfo2_phase_reset pulses", 32'h0000_0000, pulses[3]);
    summarize;
  end
endmodule : modulation_processor_matrix_tb_top
